// ==== rtl/cvbp_params.svh ====
// Constants of the coprocessor virtual bus port
`ifndef CVBP_PARAMS_SVH
`define CVBP_PARAMS_SVH
`define CVBP_OP_MEM 2'h3
`define CVBP_OP_ARITH 2'h2
`define CVBP_OP3_LSB 19
`define CVBP_RD_LSB 25
`define CVBP_RS1_LSB 14
`define CVBP_OPC_LSB 5
`define CVBP_MEM_HI0 2'h2
`define CVBP_MEM_HI1 2'h3
`define CVBP_POP_HI0 5'h1a
`define CVBP_POP_HI1 5'h1b
`define CVBP_LD_SGL 4'h0
`define CVBP_LD_SR 4'h1
`define CVBP_LD_DBL 4'h3
`define CVBP_ST_SGL 4'h4
`define CVBP_ST_SR 4'h5
`define CVBP_ST_DBL 4'h7
`define CVBP_OPC_MOV 9'h001
`define CVBP_OPC_ADD 9'h041
`define CVBP_OPC_SUB 9'h045
`define CVBP_OPC_CMP 9'h051
`define CVBP_CC_EQ 2'h0
`define CVBP_CC_LT 2'h1
`define CVBP_CC_GT 2'h2
`define CVBP_CSR_CC_LSB 10
`define CVBP_CSR_TT_LSB 14
`define CVBP_CSR_RST 32'h0000_0000
`define CVBP_TT_UNIMP 3'h1
`define CVBP_TT_UNFIN 3'h2
`define CVBP_CMP_CYCLES 3
`endif

// ==== rtl/cvbp_pkg.sv ====
// Types of the coprocessor virtual bus port
package cvbp_pkg;
  typedef enum logic [0:0] {
    EX_IDLE = 1'b0,
    EX_CMP = 1'b1
  } cvbp_ex_state_t;
  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_LD = 3'b001,
    K_LDSR = 3'b010,
    K_LDD = 3'b011,
    K_ST = 3'b100,
    K_STSR = 3'b101,
    K_STD = 3'b110,
    K_OP = 3'b111
  } cvbp_kind_t;
  typedef struct packed {
    logic [29:0] addr;
    logic [31:0] ins;
  } cvbp_pair_t;
endpackage

// ==== rtl/cvbp_stream_if.sv ====
// Valid/ready word stream between the port's own modules
`timescale 1ns/1ps
`default_nettype none
interface cvbp_stream_if #(parameter int W = 62) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== rtl/cvbp_buf2.sv ====
// Two-entry instruction queue with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cvbp_buf2 #(
  parameter int W = 62
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  cvbp_stream_if.rx in_s,
  cvbp_stream_if.tx out_s
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_s.ready = (cnt_q != 2'h2);
  assign out_s.valid = (cnt_q != 2'h0);
  assign out_s.data = mem_q[rp_q];

  always_comb begin
    push = in_s.valid && in_s.ready;
    pop = out_s.valid && out_s.ready;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_s.data;
      wp_d = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    mem_q <= mem_d;
    if (sys_rst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  a_buf_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cnt_q <= 2'h2) else $error("queue count beyond two");
endmodule
`default_nettype wire

// ==== rtl/cvbp_regfile.sv ====
// Working register file, one write and two read ports
`timescale 1ns/1ps
`default_nettype none
module cvbp_regfile #(
  parameter int W = 32,
  parameter int N = 32
) (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [$clog2(N)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [$clog2(N)-1:0] raddr_a,
  output logic [W-1:0] rdata_a,
  input wire logic [$clog2(N)-1:0] raddr_b,
  output logic [W-1:0] rdata_b
);
  // Not reset: contents are undefined until software loads them
  logic [W-1:0] mem [N];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule
`default_nettype wire

// ==== rtl/cvbp_core.sv ====
// Coprocessor end of the shared virtual bus
`timescale 1ns/1ps
`default_nettype none
`include "cvbp_params.svh"
// Summary of operation
// - Shares one clock and reset with integer unit
// - Uses only upper 30 address bits
// - Fetch strobe: address now, instruction next edge
// - Capture every fetched instruction, ours or not
// - Single load one word, double two cycles
// - Own load writes bus word into register
// - Ownership of loads/stores decided by opcode only
// - Own store drives data bus, double two cycles
// - Thirty-two by 32-bit working register file
// - Status register stored and loaded via memory
// - Condition codes in status and on pins
// - Compare drops codes-valid until codes ready
// - Queued operations wait while compare is running
// - Unimplemented operation raises emulation trap
// - Overflowing operation raises unfinished trap
// - Queue entry only after integer unit dispatch
// - Abort drops instructions not yet queued
// - Dependency in decode asserts stall next cycle
// - Exception request held until acknowledge
// - Stage selects move own operation pair into queue
// - New fetch shifts pair one into pair two
module cvbp_core
  import cvbp_pkg::*;
#(
  parameter int CP_SEL = 0,
  parameter int CMP_CYCLES = `CVBP_CMP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [29:0] bus_addr_hi,
  input wire logic [31:0] bus_data_in,
  output logic [31:0] bus_data_out,
  output logic bus_data_oe,
  input wire logic fetch_cycle_indicator,
  input wire logic stage_select_first,
  input wire logic stage_select_second,
  input wire logic abort_pending,
  input wire logic exception_ack,
  output logic cond_codes_valid,
  output logic cond_code_bit0,
  output logic cond_code_bit1,
  output logic coproc_hold,
  output logic coproc_exception_req
);
  localparam logic [1:0] MEM_HI = (CP_SEL == 0) ? `CVBP_MEM_HI0
                                                : `CVBP_MEM_HI1;
  localparam logic [4:0] POP_HI = (CP_SEL == 0) ? `CVBP_POP_HI0
                                                : `CVBP_POP_HI1;
  localparam logic [7:0] CMP_LAST = 8'(CMP_CYCLES - 1);

  // Ownership comes from the opcode alone; the address is never looked at
  function automatic cvbp_kind_t kind_of(input logic [31:0] ins);
    logic [5:0] op3;
    op3 = ins[`CVBP_OP3_LSB +: 6];
    kind_of = K_NONE;
    if (ins[31:30] == `CVBP_OP_MEM && op3[5:4] == MEM_HI) begin
      case (op3[3:0])
        `CVBP_LD_SGL: kind_of = K_LD;
        `CVBP_LD_SR: kind_of = K_LDSR;
        `CVBP_LD_DBL: kind_of = K_LDD;
        `CVBP_ST_SGL: kind_of = K_ST;
        `CVBP_ST_SR: kind_of = K_STSR;
        `CVBP_ST_DBL: kind_of = K_STD;
        default: kind_of = K_NONE;
      endcase
    end else if (ins[31:30] == `CVBP_OP_ARITH && op3[5:1] == POP_HI) begin
      kind_of = K_OP;
    end
  endfunction

  cvbp_stream_if #(.W(62)) qin ();
  cvbp_stream_if #(.W(62)) qout ();

  cvbp_buf2 #(.W(62)) u_queue (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_s(qin),
    .out_s(qout)
  );

  logic rf_we;
  logic [4:0] rf_waddr, rf_raddr_a, rf_raddr_b;
  logic [31:0] rf_wdata, rf_rdata_a, rf_rdata_b;

  cvbp_regfile #(.W(32), .N(32)) u_regs (
    .clk_sys(clk_sys),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata),
    .raddr_a(rf_raddr_a),
    .rdata_a(rf_rdata_a),
    .raddr_b(rf_raddr_b),
    .rdata_b(rf_rdata_b)
  );

  // Decode pairs
  cvbp_pair_t d1_q, d1_d, d2_q, d2_d;
  logic d1v_q, d1v_d, d2v_q, d2v_d;
  logic [29:0] fa_q, fa_d;
  logic fpend_q, fpend_d;
  logic disp1, disp2, disp;
  cvbp_pair_t dpair;
  cvbp_kind_t dkind;

  always_comb begin
    disp1 = stage_select_first && d1v_q;
    disp2 = stage_select_second && d2v_q && !disp1;
    disp = disp1 || disp2;
    dpair = disp1 ? d1_q : d2_q;
    dkind = disp ? kind_of(dpair.ins) : K_NONE;
    d1_d = d1_q;
    d2_d = d2_q;
    d1v_d = d1v_q && !disp1;
    d2v_d = d2v_q && !disp2;
    fa_d = bus_addr_hi;
    fpend_d = fetch_cycle_indicator;
    if (abort_pending) begin
      d1v_d = 1'b0;
      d2v_d = 1'b0;
      fpend_d = 1'b0;
    end else if (fpend_q) begin
      // Every fetch is captured, whoever the instruction belongs to
      if (d1v_d) begin
        d2_d = d1_q;
        d2v_d = 1'b1;
      end
      d1_d = '{addr: fa_q, ins: bus_data_in};
      d1v_d = 1'b1;
    end
  end

  // One clock, lockstep with the integer unit
  always_ff @(posedge clk_sys) begin
    d1_q <= d1_d;
    d2_q <= d2_d;
    fa_q <= fa_d;
    if (sys_rst) begin
      d1v_q <= 1'b0;
      d2v_q <= 1'b0;
      fpend_q <= 1'b0;
    end else begin
      d1v_q <= d1v_d;
      d2v_q <= d2v_d;
      fpend_q <= fpend_d;
    end
  end

  // Bus transfers, execution and status
  logic [1:0] ld_cnt_q, ld_cnt_d;
  logic [4:0] ld_reg_q, ld_reg_d, st_reg_q, st_reg_d;
  logic ld_sr_q, ld_sr_d, st_more_q, st_more_d;
  logic [31:0] dout_q, dout_d, csr_q, csr_d;
  logic doe_q, doe_d, exc_q, exc_d, hold_q, hold_d, ccv_q, ccv_d;
  logic [1:0] cmp_cnt_q, cmp_cnt_d, ex_cc_q, ex_cc_d;
  logic [7:0] ex_cnt_q, ex_cnt_d;
  cvbp_ex_state_t ex_q, ex_d;
  logic [31:0] hins, sum, dif;
  logic [8:0] hopc;
  logic pop, trap, dep, cmp_push, cmp_done;
  logic [2:0] tt;

  assign qin.valid = disp && dkind == K_OP;
  assign qin.data = dpair;

  always_comb begin
    hins = qout.data[31:0];
    hopc = hins[`CVBP_OPC_LSB +: 9];
    rf_raddr_b = hins[4:0];
    sum = rf_rdata_a + rf_rdata_b;
    dif = rf_rdata_a - rf_rdata_b;
    cmp_push = qin.valid && qin.ready && dpair.ins[`CVBP_OPC_LSB +: 9]
               == `CVBP_OPC_CMP;
    ld_cnt_d = ld_cnt_q;
    ld_reg_d = ld_reg_q;
    ld_sr_d = ld_sr_q;
    st_more_d = 1'b0;
    st_reg_d = st_reg_q;
    dout_d = dout_q;
    doe_d = 1'b0;
    csr_d = csr_q;
    ex_d = ex_q;
    ex_cnt_d = ex_cnt_q;
    ex_cc_d = ex_cc_q;
    rf_we = 1'b0;
    rf_waddr = ld_reg_q;
    rf_wdata = bus_data_in;
    rf_raddr_a = hins[`CVBP_RS1_LSB +: 5];
    trap = 1'b0;
    tt = `CVBP_TT_UNIMP;
    cmp_done = 1'b0;
    // Stores read port a; execution waits during load words and register stores, not status stores
    pop = qout.valid && ex_q == EX_IDLE && !exc_q && ld_cnt_q == 2'h0 &&
          !st_more_q && !(dkind inside {K_ST, K_STD});
    qout.ready = pop;
    if (dkind inside {K_ST, K_STD, K_STSR}) begin
      rf_raddr_a = dpair.ins[`CVBP_RD_LSB +: 5];
      dout_d = (dkind == K_STSR) ? csr_q : rf_rdata_a;
      doe_d = 1'b1;
      st_more_d = (dkind == K_STD);
      st_reg_d = dpair.ins[`CVBP_RD_LSB +: 5] + 5'h1;
    end else if (st_more_q) begin
      rf_raddr_a = st_reg_q;
      dout_d = rf_rdata_a;
      doe_d = 1'b1;
    end
    if (ld_cnt_q != 2'h0) begin
      // The integer unit supplies the address; this end only takes the word
      if (ld_sr_q) begin
        csr_d = bus_data_in;
      end else begin
        rf_we = 1'b1;
      end
      ld_cnt_d = ld_cnt_q - 2'h1;
      ld_reg_d = ld_reg_q + 5'h1;
    end
    if (dkind inside {K_LD, K_LDD, K_LDSR}) begin
      ld_cnt_d = (dkind == K_LDD) ? 2'h2 : 2'h1;
      ld_reg_d = dpair.ins[`CVBP_RD_LSB +: 5];
      ld_sr_d = (dkind == K_LDSR);
    end
    unique case (ex_q)
      EX_IDLE: begin
        if (pop) begin
          rf_waddr = hins[`CVBP_RD_LSB +: 5];
          unique case (hopc)
            `CVBP_OPC_MOV: begin
              rf_we = 1'b1;
              rf_wdata = rf_rdata_b;
            end
            `CVBP_OPC_ADD: begin
              rf_wdata = sum;
              trap = rf_rdata_a[31] == rf_rdata_b[31] &&
                     sum[31] != rf_rdata_a[31];
              rf_we = !trap;
              tt = `CVBP_TT_UNFIN;
            end
            `CVBP_OPC_SUB: begin
              rf_wdata = dif;
              trap = rf_rdata_a[31] != rf_rdata_b[31] &&
                     dif[31] != rf_rdata_a[31];
              rf_we = !trap;
              tt = `CVBP_TT_UNFIN;
            end
            `CVBP_OPC_CMP: begin
              ex_d = EX_CMP;
              ex_cnt_d = CMP_LAST;
              if (rf_rdata_a == rf_rdata_b) begin
                ex_cc_d = `CVBP_CC_EQ;
              end else if ($signed(rf_rdata_a) < $signed(rf_rdata_b)) begin
                ex_cc_d = `CVBP_CC_LT;
              end else begin
                ex_cc_d = `CVBP_CC_GT;
              end
            end
            default: trap = 1'b1;
          endcase
        end
      end
      EX_CMP: begin
        if (ex_cnt_q == 8'h00) begin
          ex_d = EX_IDLE;
          cmp_done = 1'b1;
          csr_d[`CVBP_CSR_CC_LSB +: 2] = ex_cc_q;
        end else begin
          ex_cnt_d = ex_cnt_q - 8'h01;
        end
      end
    endcase
    if (trap) begin
      csr_d[`CVBP_CSR_TT_LSB +: 3] = tt;
    end
    // A new trap in the acknowledge cycle is kept, not lost
    exc_d = (exc_q && !exception_ack) || trap;
    cmp_cnt_d = cmp_cnt_q + {1'b0, cmp_push} - {1'b0, cmp_done};
    ccv_d = (cmp_cnt_d == 2'h0);
    dep = d1v_q && kind_of(d1_q.ins) != K_NONE &&
          (ld_cnt_q != 2'h0 || st_more_q || !qin.ready || exc_q);
    hold_d = dep;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ld_cnt_q <= 2'h0;
      ld_reg_q <= 5'h00;
      ld_sr_q <= 1'b0;
      st_more_q <= 1'b0;
      st_reg_q <= 5'h00;
      dout_q <= 32'h0000_0000;
      doe_q <= 1'b0;
      csr_q <= `CVBP_CSR_RST;
      ex_q <= EX_IDLE;
      ex_cnt_q <= 8'h00;
      ex_cc_q <= 2'h0;
      exc_q <= 1'b0;
      hold_q <= 1'b0;
      ccv_q <= 1'b1;
      cmp_cnt_q <= 2'h0;
    end else begin
      ld_cnt_q <= ld_cnt_d;
      ld_reg_q <= ld_reg_d;
      ld_sr_q <= ld_sr_d;
      st_more_q <= st_more_d;
      st_reg_q <= st_reg_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      csr_q <= csr_d;
      ex_q <= ex_d;
      ex_cnt_q <= ex_cnt_d;
      ex_cc_q <= ex_cc_d;
      exc_q <= exc_d;
      hold_q <= hold_d;
      ccv_q <= ccv_d;
      cmp_cnt_q <= cmp_cnt_d;
    end
  end

  // No address outputs: the integer unit addresses every transfer
  assign bus_data_out = dout_q;
  assign bus_data_oe = doe_q;
  assign cond_codes_valid = ccv_q;
  assign cond_code_bit0 = csr_q[`CVBP_CSR_CC_LSB];
  assign cond_code_bit1 = csr_q[`CVBP_CSR_CC_LSB + 1];
  assign coproc_hold = hold_q;
  assign coproc_exception_req = exc_q;

  a_fetch_capture: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fetch_cycle_indicator && !abort_pending ##1 !abort_pending |=> d1v_q &&
    d1_q.ins == $past(bus_data_in) && d1_q.addr == $past(bus_addr_hi, 2))
    else $error("fetched pair not captured");
  a_flush_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
    abort_pending |=> !d1v_q && !d2v_q)
    else $error("abort left a decode pair");
  a_ccv_compare: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cmp_push |=> !cond_codes_valid)
    else $error("codes valid during compare");
  a_ccv_run_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ex_q == EX_CMP |-> !cond_codes_valid && !qout.ready)
    else $error("compare not interlocked");
  a_exc_drop: assert property (@(posedge clk_sys) disable iff (sys_rst)
    exception_ack && !trap |=> !coproc_exception_req)
    else $error("request kept after acknowledge");
  a_exc_held: assert property (@(posedge clk_sys) disable iff (sys_rst)
    coproc_exception_req && !exception_ack |=> coproc_exception_req)
    else $error("request dropped without acknowledge");
  a_store_double: assert property (@(posedge clk_sys) disable iff (sys_rst)
    dkind == K_STD |=> bus_data_oe [*2])
    else $error("double store not two cycles");
  a_load_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
    dkind == K_LDD |=> ld_cnt_q == 2'h2 ##1 ld_cnt_q == 2'h1)
    else $error("double load not two words");
  a_hold_next: assert property (@(posedge clk_sys) disable iff (sys_rst)
    dep |=> coproc_hold)
    else $error("stall not raised after dependency");
  a_queue_room: assert property (@(posedge clk_sys) disable iff (sys_rst)
    qin.valid |-> qin.ready)
    else $error("dispatch into full queue");
endmodule
`default_nettype wire

// ==== tb/cvbp_iu_model.sv ====
// Integer unit partner: memory data bus and trap acknowledge
`timescale 1ns/1ps
`default_nettype none
module cvbp_iu_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic drv_en,
  input wire logic [31:0] drv_data,
  input wire logic ack_slow,
  input wire logic coproc_exception_req,
  output logic exception_ack,
  output logic [31:0] bus_data_in
);
  logic [31:0] last_q = 32'h0;
  logic [3:0] wait_q = 4'h0;
  logic ack_q = 1'b0;
  assign exception_ack = ack_q;
  // Released bus shows the inverse of the last word, never a stale copy
  assign bus_data_in = drv_en ? drv_data : ~last_q;
  // Same clock and reset as the coprocessor
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      last_q <= 32'h0;
      wait_q <= 4'h0;
      ack_q <= 1'b0;
    end else begin
      if (drv_en) begin
        last_q <= drv_data;
      end
      // Trap taken after a short or long latency, one pulse only
      if (coproc_exception_req && !ack_q) begin
        ack_q <= (wait_q == (ack_slow ? 4'h9 : 4'h1));
        wait_q <= wait_q + 4'h1;
      end else begin
        ack_q <= 1'b0;
        wait_q <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/cvbp_core_tb.sv ====
// Self-checking bench of the coprocessor virtual bus port
`timescale 1ns/1ps
`default_nettype none
`include "cvbp_params.svh"
module cvbp_core_tb;
  localparam logic [31:0] W1 = 32'h1234_5678;
  localparam logic [31:0] W2 = 32'h8000_0001;
  localparam logic [31:0] W3 = 32'h0000_00ff;
  localparam logic [31:0] SR = {30'h0, `CVBP_CC_GT} << `CVBP_CSR_CC_LSB;
  logic clk_sys, sys_rst, fci, ss1, ss2, abort_pending, drv_en, ack_slow;
  logic [29:0] addr;
  logic [31:0] drv_data, bus_in, dout;
  logic oe, cc_valid, code_b0, code_b1, hold, exc_req, ack;
  int err_count, n_tests;

  cvbp_core dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus_addr_hi(addr), .bus_data_in(bus_in), .bus_data_out(dout),
    .bus_data_oe(oe), .fetch_cycle_indicator(fci),
    .stage_select_first(ss1), .stage_select_second(ss2),
    .abort_pending(abort_pending), .exception_ack(ack),
    .cond_codes_valid(cc_valid), .cond_code_bit0(code_b0),
    .cond_code_bit1(code_b1), .coproc_hold(hold),
    .coproc_exception_req(exc_req));
  cvbp_iu_model iu_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .drv_en(drv_en), .drv_data(drv_data), .ack_slow(ack_slow),
    .coproc_exception_req(exc_req), .exception_ack(ack),
    .bus_data_in(bus_in));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] mem(input logic [3:0] k,
                                      input logic [4:0] rd, input logic own);
    return {2'h3, rd, own ? `CVBP_MEM_HI0 : `CVBP_MEM_HI1, k, 19'h0};
  endfunction

  function automatic logic [31:0] alu(input logic [8:0] opc,
    input logic [4:0] rd, input logic [4:0] rs1, input logic [4:0] rs2);
    return {2'h2, rd, `CVBP_POP_HI0, 1'b0, rs1, opc, rs2};
  endfunction

  // Address in the strobe cycle, instruction word one edge later
  task automatic fetch(input logic [29:0] a, input logic [31:0] ins);
    fci <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    fci <= 1'b0;
    drv_en <= 1'b1;
    drv_data <= ins;
    @(posedge clk_sys);
    drv_en <= 1'b0;
  endtask

  // Hold is sampled a cycle late, so give it time to show first
  task automatic free();
    int k;
    k = 0;
    repeat (2) @(posedge clk_sys);
    while (hold === 1'b1 && k < 50) begin
      @(posedge clk_sys);
      k++;
    end
    check("hold release", hold, 1'b0);
  endtask

  task automatic op(input logic sel2, input int nw, input logic st,
                    input logic [31:0] w0, input logic [31:0] w1);
    free();
    ss1 <= ~sel2;
    ss2 <= sel2;
    @(posedge clk_sys);
    ss1 <= 1'b0;
    ss2 <= 1'b0;
    for (int i = 0; i < nw; i++) begin
      drv_en <= ~st;
      drv_data <= i ? w1 : w0;
      #1;
      if (st) check("store word", dout, i ? w1 : w0);
      if (st) check("store drive", oe, 1'b1);
      @(posedge clk_sys);
    end
    drv_en <= 1'b0;
    #1;
    check("bus released", oe, 1'b0);
    @(posedge clk_sys);
  endtask

  task automatic t_reset();
    repeat (20) @(posedge clk_sys);
    check("codes valid", cc_valid, 1'b1);
    check("code pins", {code_b1, code_b0}, 2'h0);
    check("hold", hold, 1'b0);
    check("request", exc_req, 1'b0);
    check("drive", oe, 1'b0);
    check("data out", dout, 32'h0);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic t_move();
    fetch(30'h0000_0100, mem(`CVBP_LD_SGL, 5'h1, 1'b1));
    op(1'b0, 1, 1'b0, W1, 32'h0);
    fetch(30'h0000_0101, mem(`CVBP_LD_DBL, 5'h2, 1'b1));
    op(1'b0, 2, 1'b0, W2, W3);
    fetch(30'h0000_0102, mem(`CVBP_LD_SGL, 5'h1, 1'b0));
    op(1'b0, 1, 1'b0, 32'hdead_beef, 32'h0);
    fetch(30'h0000_0103, mem(`CVBP_ST_SGL, 5'h1, 1'b1));
    op(1'b0, 1, 1'b1, W1, 32'h0);
    fetch(30'h3fff_ffff, mem(`CVBP_ST_DBL, 5'h2, 1'b1));
    op(1'b0, 2, 1'b1, W2, W3);
    fetch(30'h0000_0105, mem(`CVBP_ST_SGL, 5'h1, 1'b0));
    op(1'b0, 0, 1'b1, 32'h0, 32'h0);
  endtask

  // Double load in flight ahead of an own instruction must stall the unit
  task automatic t_hold();
    fetch(30'h080, mem(`CVBP_LD_DBL, 5'h8, 1'b1));
    fetch(30'h081, mem(`CVBP_ST_SGL, 5'h8, 1'b1));
    op(1'b1, 2, 1'b0, W1, W2);
    check("hold raised", hold, 1'b1);
    op(1'b0, 1, 1'b1, W1, 32'h0);
  endtask

  task automatic t_alu();
    fetch(30'h090, alu(`CVBP_OPC_MOV, 5'ha, 5'h0, 5'h3));
    op(1'b0, 0, 1'b0, 32'h0, 32'h0);
    fetch(30'h091, alu(`CVBP_OPC_SUB, 5'hb, 5'h1, 5'h3));
    op(1'b0, 0, 1'b0, 32'h0, 32'h0);
    fetch(30'h092, mem(`CVBP_ST_DBL, 5'ha, 1'b1));
    op(1'b0, 2, 1'b1, W3, 32'h1234_5579);
  endtask

  task automatic t_shift();
    fetch(30'h200, mem(`CVBP_ST_SGL, 5'h3, 1'b1));
    fetch(30'h201, 32'h0100_0000);
    op(1'b1, 1, 1'b1, W3, 32'h0);
  endtask

  task automatic t_abort();
    fetch(30'h300, mem(`CVBP_ST_SGL, 5'h1, 1'b1));
    fetch(30'h301, mem(`CVBP_ST_SGL, 5'h2, 1'b1));
    abort_pending <= 1'b1;
    @(posedge clk_sys);
    abort_pending <= 1'b0;
    op(1'b0, 0, 1'b1, 32'h0, 32'h0);
    op(1'b1, 0, 1'b1, 32'h0, 32'h0);
  endtask

  task automatic t_compare();
    int n;
    n = 0;
    fetch(30'h400, alu(`CVBP_OPC_CMP, 5'h0, 5'h2, 5'h3));
    repeat (3) @(posedge clk_sys);
    check("codes valid", cc_valid, 1'b1);
    free();
    ss1 <= 1'b1;
    @(posedge clk_sys);
    ss1 <= 1'b0;
    @(posedge clk_sys);
    check("codes valid", cc_valid, 1'b0);
    // Code pins keep the old codes until valid again
    while (cc_valid !== 1'b1 && n < 20) begin
      check("code pins", {code_b1, code_b0}, 2'h0);
      @(posedge clk_sys);
      n++;
    end
    check("codes valid", cc_valid, 1'b1);
    check("code pins", {code_b1, code_b0}, `CVBP_CC_LT);
  endtask

  task automatic t_status();
    fetch(30'h500, mem(`CVBP_ST_SR, 5'h0, 1'b1));
    op(1'b0, 1, 1'b1, {30'h0, `CVBP_CC_LT} << `CVBP_CSR_CC_LSB,
       32'h0);
    fetch(30'h501, mem(`CVBP_LD_SR, 5'h0, 1'b1));
    op(1'b0, 1, 1'b0, SR, 32'h0);
    check("code pins", {code_b1, code_b0}, `CVBP_CC_GT);
  endtask

  task automatic t_trap(input logic [31:0] ins, input logic slow,
                        input logic [2:0] tt);
    int n;
    logic span_ok;
    n = 0;
    ack_slow <= slow;
    fetch(30'h600, ins);
    op(1'b0, 0, 1'b0, 32'h0, 32'h0);
    while (exc_req !== 1'b1 && n < 30) begin
      @(posedge clk_sys);
      n++;
    end
    n = 0;
    while (exc_req === 1'b1 && n < 30) begin
      @(posedge clk_sys);
      n++;
    end
    span_ok = n > (slow ? 9 : 0) && n < (slow ? 13 : 5);
    check("request span", span_ok, 1'b1);
    fetch(30'h601, mem(`CVBP_ST_SR, 5'h0, 1'b1));
    op(1'b0, 1, 1'b1, SR | ({29'h0, tt} << `CVBP_CSR_TT_LSB),
       32'h0);
  endtask

  task automatic t_traps();
    t_trap(alu(9'h1ff, 5'h6, 5'h1, 5'h1), 1'b1, `CVBP_TT_UNIMP);
    fetch(30'h700, mem(`CVBP_LD_SGL, 5'h4, 1'b1));
    op(1'b0, 1, 1'b0, 32'h7fff_ffff, 32'h0);
    t_trap(alu(`CVBP_OPC_ADD, 5'h5, 5'h4, 5'h4), 1'b0,
           `CVBP_TT_UNFIN);
  endtask

  initial begin
    err_count = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    {fci, ss1, ss2, abort_pending, drv_en, ack_slow} = 6'h0;
    addr = 30'h0;
    drv_data = 32'h0;
    t_reset();
    t_move();
    t_hold();
    t_alu();
    t_shift();
    t_abort();
    t_compare();
    t_status();
    t_traps();
    conclude();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
